// file: common/pps_params.svh
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPS_IDX_CTRL 18'h06040
`define PPS_IDX_STAT 18'h06041
`define PPS_IDX_MODE 18'h06060
`define PPS_IDX_TARGET 18'h0607A
`define PPS_IDX_SWMIN 18'h0607D
`define PPS_IDX_SWMAX 18'h0607E
`define PPS_IDX_TOLZONE 18'h02056
`define PPS_IDX_POSOPT 18'h060F2
`define PPS_IDX_HALTOPT 18'h0605D
`define PPS_IDX_POSWIN 18'h06067
`define PPS_IDX_POSWINTIME 18'h06068
`define PPS_IDX_FEWIN 18'h06065
`define PPS_IDX_FETIME 18'h06066
`define PPS_IDX_PROFVEL 18'h06081
`define PPS_IDX_PROFACC 18'h06083
`define PPS_IDX_PROFDEC 18'h06084
`define PPS_IDX_ACTPOS 18'h06064
`define PPS_IDX_DEMPOS 18'h06062
`define PPS_IDX_LOOPCFG 18'h03000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPS_CW_NEWSP 4
`define PPS_CW_IMMED 5
`define PPS_CW_REL 6
`define PPS_CW_FLTRST 7
`define PPS_CW_HALT 8
`define PPS_CW_PASS 9
`define PPS_SW_FAULT 3
`define PPS_SW_REACHED 10
`define PPS_SW_ACK 12
`define PPS_SW_FOLLOW 13
`define PPS_MODE_PROFPOS 8'h01

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define PPS_RST_SWMIN 32'h80000000
`define PPS_RST_SWMAX 32'h7FFFFFFF
`define PPS_RST_ZERO 32'h00000000
`define PPS_RST_PROFVEL 32'h00000010
`define PPS_RST_PROFACC 32'h00000004
`define PPS_RST_PROFDEC 32'h00000004
`define PPS_CYCLE_NS 1000000
`define PPS_CLK_PERIOD_PS 5000

`endif

// file: common/pps_pkg.sv
package pps_pkg;
  // Motion set point: target and its own ramp parameters.
  typedef struct packed {
    logic signed [31:0] target;
    logic [31:0] velocity;
    logic [31:0] accel;
    logic [31:0] decel;
    logic passThrough;
  } pps_setpoint_type;

  typedef enum logic [1:0] {PPS_IDLE, PPS_MOVE, PPS_FAULT} pps_state_type;
endpackage

// file: src/pps_sequencer.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "pps_params.svh"

// Overview of operation
// R1 - Free movement inside a zone past each limit switch, zone length configurable.
// R2 - Entering the range beyond the zone stops at once and enters fault.
// R3 - Targets are clamped to software limits; demand never passes them.
// R4 - Outside the permitted range only commands heading back are accepted.
// R5 - Inputs and objects are sampled once per 1 ms cycle.
// R6 - Host writes 1 into operating-mode select for profile position.
// R7 - A move starts on a rising edge of control bit 4.
// R8 - Entering profile position with bit 4 high starts the move.
// R9 - Bit 5 high executes at once; low queues behind the running move.
// R10 - Bit 6 selects absolute or relative; option bits 1:0 pick reference.
// R11 - Option value 0 makes relative moves from the preceding target.
// R12 - Bit 8 rising brakes to standstill; falling ramps back up.
// R13 - Bit 9 with bit 5 low passes the target without braking.
// R14 - Bit 9 is ignored when target speed is not reached at the target.
// R15 - Status bit 10 sets when in the window for the dwell time.
// R16 - Status bit 12 acknowledges a valid set point, following bit 4.
// R17 - Queued: acknowledge clears when another can be taken; commands during it drop.
// R18 - Acknowledge is withheld for an unreachable target.
// R19 - Status bit 13 sets on following error beyond window past timeout.
// R20 - Device clears bit 4 itself when option bits 5:4 say so.
// R21 - One pending set point is buffered; arrivals when full are dropped.
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int TICK_CYCLES = `PPS_CYCLE_NS * 1000 / `PPS_CLK_PERIOD_PS
) (
  input wire logic ref_clk, // 200 MHz clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [19:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic [31:0] actualPos, // Encoder position from outside the domain.
  input wire logic posLimitSw, // Positive limit switch pin.
  input wire logic negLimitSw, // Negative limit switch pin.
  output logic signed [31:0] demandPos, // Demanded position to the position loop.
  output logic faultState // Drive in fault after limit violation.
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [7:0] mode_r;
  logic signed [31:0] target_r, swMin_r, swMax_r;
  logic [31:0] tolZone_r, posOpt_r, haltOpt_r, posWin_r, posWinTime_r;
  logic [31:0] feWin_r, feTime_r, profVel_r, profAcc_r, profDec_r, rdMux;
  logic closedLoop_r, ack_r, reached_r, follow_r, autoClear, hit, access;

  // Sampled, synchronised inputs.
  logic [31:0] actMeta_r, actSync_r;
  logic [1:0] limMeta_r, limSync_r;

  // Cycle tick.
  logic [31:0] tickCnt_r;
  logic tick_r;

  // Motion state.
  pps_state_type state_r;
  pps_setpoint_type act_r, buf_r, newSp;
  logic bufValid_r, newSpPrev_r, inMode_r, halting, arrive, limitTrip;
  logic [31:0] speed_r;
  logic signed [31:0] demand_r;

  assign access = psel && penable && !pready;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Address decode for reads; an unmapped index answers with an error.
  always_comb begin
    hit = 1'b1;
    rdMux = 32'h00000000;
    case (paddr[19:2])
      `PPS_IDX_CTRL: rdMux = {16'h0000, ctrl_r};
      `PPS_IDX_STAT: rdMux = {16'h0000, 2'b00, follow_r, ack_r, 1'b0, reached_r,
                              6'h00, faultState, 3'h0};
      `PPS_IDX_MODE: rdMux = {24'h000000, mode_r};
      `PPS_IDX_TARGET: rdMux = target_r;
      `PPS_IDX_SWMIN: rdMux = swMin_r;
      `PPS_IDX_SWMAX: rdMux = swMax_r;
      `PPS_IDX_TOLZONE: rdMux = tolZone_r;
      `PPS_IDX_POSOPT: rdMux = posOpt_r;
      `PPS_IDX_HALTOPT: rdMux = haltOpt_r;
      `PPS_IDX_POSWIN: rdMux = posWin_r;
      `PPS_IDX_POSWINTIME: rdMux = posWinTime_r;
      `PPS_IDX_FEWIN: rdMux = feWin_r;
      `PPS_IDX_FETIME: rdMux = feTime_r;
      `PPS_IDX_PROFVEL: rdMux = profVel_r;
      `PPS_IDX_PROFACC: rdMux = profAcc_r;
      `PPS_IDX_PROFDEC: rdMux = profDec_r;
      `PPS_IDX_ACTPOS: rdMux = actSync_r;
      `PPS_IDX_DEMPOS: rdMux = demand_r;
      `PPS_IDX_LOOPCFG: rdMux = {31'h00000000, closedLoop_r};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: the answer comes in the second access cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !hit;
      prdata <= (access && !pwrite) ? rdMux : 32'h00000000;
    end
  end

  // Writable objects land at the edge where the master sees ready. A software
  // write of the control word wins over the device clearing bit 4, so no edge is lost.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 16'h0000;
      mode_r <= 8'h00;
      target_r <= `PPS_RST_ZERO;
      swMin_r <= `PPS_RST_SWMIN;
      swMax_r <= `PPS_RST_SWMAX;
      tolZone_r <= `PPS_RST_ZERO;
      posOpt_r <= `PPS_RST_ZERO;
      haltOpt_r <= `PPS_RST_ZERO;
      posWin_r <= `PPS_RST_ZERO;
      posWinTime_r <= `PPS_RST_ZERO;
      feWin_r <= `PPS_RST_ZERO;
      feTime_r <= `PPS_RST_ZERO;
      profVel_r <= `PPS_RST_PROFVEL;
      profAcc_r <= `PPS_RST_PROFACC;
      profDec_r <= `PPS_RST_PROFDEC;
      closedLoop_r <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr[19:2])
        `PPS_IDX_CTRL: ctrl_r <= pwdata[15:0];
        `PPS_IDX_MODE: mode_r <= pwdata[7:0]; // R6
        `PPS_IDX_TARGET: target_r <= pwdata;
        `PPS_IDX_SWMIN: swMin_r <= pwdata;
        `PPS_IDX_SWMAX: swMax_r <= pwdata;
        `PPS_IDX_TOLZONE: tolZone_r <= pwdata;
        `PPS_IDX_POSOPT: posOpt_r <= pwdata;
        `PPS_IDX_HALTOPT: haltOpt_r <= pwdata;
        `PPS_IDX_POSWIN: posWin_r <= pwdata;
        `PPS_IDX_POSWINTIME: posWinTime_r <= pwdata;
        `PPS_IDX_FEWIN: feWin_r <= pwdata;
        `PPS_IDX_FETIME: feTime_r <= pwdata;
        `PPS_IDX_PROFVEL: profVel_r <= pwdata;
        `PPS_IDX_PROFACC: profAcc_r <= pwdata;
        `PPS_IDX_PROFDEC: profDec_r <= pwdata;
        `PPS_IDX_LOOPCFG: closedLoop_r <= pwdata[0];
        default: ;
      endcase
    end else if (autoClear) begin
      ctrl_r[`PPS_CW_NEWSP] <= 1'b0; // R20
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and the 1 ms cycle
  // ----------------------------------------------------------------------
  // Two flops on every pin; the position bus is only meaningful when stable.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      actMeta_r <= 32'h00000000;
      actSync_r <= 32'h00000000;
      limMeta_r <= 2'b00;
      limSync_r <= 2'b00;
    end else begin
      actMeta_r <= actualPos;
      actSync_r <= actMeta_r;
      limMeta_r <= {posLimitSw, negLimitSw};
      limSync_r <= limMeta_r;
    end
  end

  // Everything below acts only on the tick, so several changes inside one
  // cycle collapse into the last one.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickCnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tickCnt_r == 32'(TICK_CYCLES - 1)); // R5
      tickCnt_r <= (tickCnt_r == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tickCnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------------
  logic inPp, trig, rawOut, badDir, accept;
  logic signed [31:0] relBase, rawTgt, actS;

  always_comb begin
    actS = actSync_r;
    inPp = (mode_r == `PPS_MODE_PROFPOS);
    // Entering the mode with bit 4 already set counts as an edge.
    trig = tick_r && inPp && ctrl_r[`PPS_CW_NEWSP] &&
           (!newSpPrev_r || !inMode_r); // R7 R8
    case (posOpt_r[1:0])
      2'b01: relBase = demand_r; // R10
      2'b10: relBase = actS;
      default: relBase = act_r.target; // R11
    endcase
    rawTgt = ctrl_r[`PPS_CW_REL] ? relBase + target_r : target_r; // R10
    rawOut = (rawTgt > swMax_r) || (rawTgt < swMin_r);
    // Outside the range, only a target heading back is taken.
    badDir = ((actS > swMax_r) && (rawTgt >= actS)) ||
             ((actS < swMin_r) && (rawTgt <= actS)); // R4
    newSp.target = rawOut ? ((rawTgt > swMax_r) ? swMax_r : swMin_r) : rawTgt; // R3
    newSp.velocity = profVel_r;
    newSp.accel = profAcc_r;
    newSp.decel = profDec_r;
    newSp.passThrough = ctrl_r[`PPS_CW_PASS] && !ctrl_r[`PPS_CW_IMMED]; // R13
    // Unreachable targets, a busy acknowledge or a full buffer are refused.
    accept = trig && !ack_r && !badDir && (profVel_r != 32'h0) &&
             (state_r != PPS_FAULT) &&
             (ctrl_r[`PPS_CW_IMMED] || state_r == PPS_IDLE || !bufValid_r); // R17 R18 R21
    autoClear = accept && (posOpt_r[5:4] != 2'b00); // R20
  end

  // Acknowledge follows bit 4; in queued use it stays up while the buffer
  // is occupied, so the host cannot overwrite a pending set point.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      newSpPrev_r <= 1'b0;
      inMode_r <= 1'b0;
    end else if (tick_r) begin
      newSpPrev_r <= ctrl_r[`PPS_CW_NEWSP];
      inMode_r <= inPp;
      if (accept) begin
        ack_r <= 1'b1; // R16
      end else if (!ctrl_r[`PPS_CW_NEWSP] && !bufValid_r) begin
        ack_r <= 1'b0; // R16 R17
      end
    end
  end

  // ----------------------------------------------------------------------
  // Profile generator
  // ----------------------------------------------------------------------
  logic signed [31:0] remain;
  logic [31:0] distAbs, spdUp, spdDn, spdNew, step;

  always_comb begin
    remain = act_r.target - demand_r;
    distAbs = remain[31] ? 32'(-remain) : 32'(remain);
    halting = ctrl_r[`PPS_CW_HALT];
    spdUp = (speed_r + act_r.accel > act_r.velocity) ? act_r.velocity
                                                     : speed_r + act_r.accel;
    // Halt option zero brakes on the profile ramp, any other value stops dead.
    spdDn = (haltOpt_r != 32'h0 || speed_r < act_r.decel) ? 32'h0
                                                          : speed_r - act_r.decel; // R12
    spdNew = halting ? spdDn : spdUp; // R12
    step = (spdNew > distAbs) ? distAbs : spdNew;
    arrive = (state_r == PPS_MOVE) && (spdNew >= distAbs) && !halting;
  end

  // Per-cycle motion update; the demand can only move toward a clamped
  // target, which keeps it inside the software limits.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= PPS_IDLE;
      act_r <= '0;
      buf_r <= '0;
      bufValid_r <= 1'b0;
      speed_r <= 32'h0;
      demand_r <= 32'sh0;
    end else if (tick_r) begin
      case (state_r)
        PPS_IDLE: begin // Demand holds at standstill, inside the limits.
          if (accept) begin
            act_r <= newSp;
            state_r <= PPS_MOVE;
          end
        end
        PPS_MOVE: begin
          demand_r <= remain[31] ? demand_r - $signed(step) : demand_r + $signed(step); // R3
          speed_r <= spdNew;
          if (accept && ctrl_r[`PPS_CW_IMMED]) begin
            act_r <= newSp; // R9
            bufValid_r <= 1'b0;
          end else if (accept) begin
            buf_r <= newSp; // R9 R21
            bufValid_r <= 1'b1;
          end
          if (arrive && bufValid_r) begin
            act_r <= buf_r;
            bufValid_r <= 1'b0;
            // Pass through only when the cruise speed was held to the point.
            if (!(buf_r.passThrough && spdNew >= act_r.velocity)) begin
              speed_r <= 32'h0; // R13 R14
            end
          end else if (arrive && !(accept && ctrl_r[`PPS_CW_IMMED])) begin
            state_r <= PPS_IDLE;
            speed_r <= 32'h0;
          end
        end
        PPS_FAULT: begin // Demand freezes, so the stop is immediate.
          if (ctrl_r[`PPS_CW_FLTRST] && !limitTrip) begin
            state_r <= PPS_IDLE;
          end
        end
        default: state_r <= PPS_IDLE;
      endcase
      if (limitTrip) begin
        state_r <= PPS_FAULT; // R2
        speed_r <= 32'h0;
        bufValid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Limit switch tolerance zones
  // ----------------------------------------------------------------------
  logic signed [31:0] posEdge_r, negEdge_r;
  logic [1:0] limSeen_r;

  // Capture where each switch was first seen; travel past it is free for
  // the zone length, beyond that the drive trips.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      posEdge_r <= 32'sh0;
      negEdge_r <= 32'sh0;
      limSeen_r <= 2'b00;
    end else if (tick_r) begin
      limSeen_r <= limSync_r;
      if (limSync_r[1] && !limSeen_r[1]) begin
        posEdge_r <= actS;
      end
      if (limSync_r[0] && !limSeen_r[0]) begin
        negEdge_r <= actS;
      end
    end
  end

  assign limitTrip = (limSeen_r[1] && limSync_r[1] &&
                      (actS > posEdge_r + $signed(tolZone_r))) ||
                     (limSeen_r[0] && limSync_r[0] &&
                      (actS < negEdge_r - $signed(tolZone_r))); // R1 R2

  // ----------------------------------------------------------------------
  // Target reached and following error monitors
  // ----------------------------------------------------------------------
  logic signed [31:0] tgtErr, folErr;
  logic [31:0] winCnt_r, feCnt_r;

  always_comb begin
    tgtErr = act_r.target - actS;
    folErr = demand_r - actS;
  end

  // Dwell and timeout counters run in 1 ms cycles.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      winCnt_r <= 32'h0;
      feCnt_r <= 32'h0;
      reached_r <= 1'b0;
      follow_r <= 1'b0;
    end else if (tick_r) begin
      if (state_r == PPS_IDLE && !bufValid_r &&
          (tgtErr[31] ? 32'(-tgtErr) : 32'(tgtErr)) <= posWin_r) begin
        winCnt_r <= (winCnt_r >= posWinTime_r) ? winCnt_r : winCnt_r + 32'h1;
        reached_r <= (winCnt_r >= posWinTime_r); // R15
      end else begin
        winCnt_r <= 32'h0;
        reached_r <= 1'b0;
      end
      if (closedLoop_r && (folErr[31] ? 32'(-folErr) : 32'(folErr)) > feWin_r) begin
        feCnt_r <= (feCnt_r > feTime_r) ? feCnt_r : feCnt_r + 32'h1;
        follow_r <= (feCnt_r >= feTime_r); // R19
      end else begin
        feCnt_r <= 32'h0;
        follow_r <= 1'b0;
      end
    end
  end

  // Outputs straight from flops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      demandPos <= 32'sh0;
      faultState <= 1'b0;
    end else begin
      demandPos <= demand_r;
      faultState <= (state_r == PPS_FAULT); // R2
    end
  end

endmodule

// file: verification/pps_sequencer_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks for the move sequencer
// ----------------------------------------
module pps_sequencer_properties #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic signed [31:0] demandPos, // Demand position.
  input wire logic faultState // Fault.
);
  logic signed [31:0] lastDemand_r;
  int gap_r;

  // Cycles since the demand last moved; starts saturated so reset stays quiet.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastDemand_r <= '0;
      gap_r <= TICK_CYCLES;
    end else begin
      lastDemand_r <= demandPos;
      gap_r <= (demandPos != lastDemand_r) ? 1 : gap_r + int'(gap_r < TICK_CYCLES);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence answerPulse;
    pready ##1 !pready;
  endsequence

  chk_ready_one_wait: assert property (accessWait |=> answerPulse)
    else $error("ready not one cycle after access");
  chk_setup_quiet: assert property (psel && !penable |-> !pready)
    else $error("ready during setup");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside answer");
  chk_err_data_zero: assert property (pslverr |-> prdata == 32'h00000000)
    else $error("refused read gave data");
  chk_tick_spacing: assert property ((demandPos != lastDemand_r) |-> gap_r >= TICK_CYCLES)
    else $error("demand moved between ticks");
  chk_fault_freeze: assert property (faultState ##1 faultState |-> $stable(demandPos))
    else $error("demand moved in fault");
  chk_reset_quiet: assert property ($fell(rst) |-> !pready && !faultState && demandPos == 0)
    else $error("outputs busy after reset");
endmodule

bind pps_sequencer pps_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .demandPos(demandPos),
  .faultState(faultState)
);

// file: verification/pps_host_model.sv
`timescale 1ns/1ps
`include "pps_params.svh"
// ----------------------------------------
// Host program on the register bus
// ----------------------------------------
module pps_host_model (
  input wire logic ref_clk, // Clock.
  output logic psel, // Select.
  output logic penable, // Enable.
  output logic pwrite, // Direction.
  output logic [19:0] paddr, // Byte address.
  output logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr // Error.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h00000;
    pwdata = 32'h00000000;
  end

  // One transfer; the request stays put until ready is seen at an edge.
  task automatic xfer(input logic wr, input logic [17:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Profile position is chosen by writing one into the mode object.
  task automatic select_mode();
    logic [31:0] d;
    xfer(1'b1, `PPS_IDX_MODE, 32'h00000001, d);
  endtask

  // Bit 4 must already be low so this write is a rising edge.
  task automatic launch(input logic [31:0] bits);
    logic [31:0] d;
    xfer(1'b1, `PPS_IDX_CTRL, bits | 32'h00000010, d);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
`include "pps_params.svh"
module tb;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] value;
    logic err;
  } pps_expect_type;
  localparam int TICKS = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, faultState;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, t, d;
  logic [31:0] actualPos = 32'h00000000;
  logic posLimitSw = 1'b0, negLimitSw = 1'b0;
  logic signed [31:0] demandPos;
  logic signed [31:0] posOffset = 32'h00000000;
  logic [31:0] seed = 32'h00000039;
  int fails = 0;
  int samples_checked = 0;
  pps_expect_type expectQ[$];
  logic [17:0] resIdx [6] = '{`PPS_IDX_SWMIN, `PPS_IDX_SWMAX, `PPS_IDX_PROFVEL,
                              `PPS_IDX_PROFACC, `PPS_IDX_CTRL, `PPS_IDX_MODE};
  logic [31:0] resVal [6] = '{32'h80000000, 32'h7FFFFFFF, 32'h00000010,
                              32'h00000004, 32'h00000000, 32'h00000000};

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #2.5 ref_clk = ~ref_clk;

  pps_sequencer #(.TICK_CYCLES(TICKS)) pps_sequencer_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .actualPos(actualPos), .posLimitSw(posLimitSw),
    .negLimitSw(negLimitSw), .demandPos(demandPos), .faultState(faultState));

  pps_host_model pps_host_model_inst (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // The encoder trails the demand; the offset provokes errors and trips.
  always @(posedge ref_clk) actualPos <= demandPos + posOffset;

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read answers are matched with the oldest note; polling notes have no mask.
  always @(posedge ref_clk) begin
    pps_expect_type e;
    if (pready === 1'b1 && pwrite === 1'b0 && expectQ.size() > 0) begin
      e = expectQ.pop_front();
      if (e.mask != 32'h00000000) check(prdata & e.mask, e.value);
      if (e.mask != 32'h00000000 || e.err) check({31'h0, pslverr}, {31'h0, e.err});
    end
  end

  task automatic wr(input logic [17:0] idx, input logic [31:0] v);
    logic [31:0] junk;
    pps_host_model_inst.xfer(1'b1, idx, v, junk);
  endtask

  task automatic rd(input logic [17:0] idx, input logic [31:0] mask,
                    input logic [31:0] v, input logic err, output logic [31:0] q);
    expectQ.push_back({mask, v, err});
    pps_host_model_inst.xfer(1'b0, idx, 32'h00000000, q);
  endtask

  // Reads until the field matches or the limit runs out, then a checked read.
  task automatic poll(input logic [17:0] idx, input logic [31:0] mask, input logic [31:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    q = ~v;
    while (((q & mask) !== v) && n < 300) begin
      rd(idx, 32'h00000000, 32'h00000000, 1'b0, q);
      n++;
    end
    rd(idx, mask, v, 1'b0, q);
  endtask

  task automatic move(input logic [31:0] tgt, input logic [31:0] bits, input logic [31:0] exp);
    wr(`PPS_IDX_CTRL, bits);
    poll(`PPS_IDX_STAT, 32'h00001000, 32'h00000000);
    wr(`PPS_IDX_TARGET, tgt);
    pps_host_model_inst.launch(bits);
    poll(`PPS_IDX_STAT, 32'h00001000, 32'h00001000);
    poll(`PPS_IDX_DEMPOS, 32'hFFFFFFFF, exp);
    check(demandPos, exp);
  endtask

  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(resIdx[i], 32'hFFFFFFFF, resVal[i], 1'b0, d);
    rd(18'h00010, 32'hFFFFFFFF, 32'h00000000, 1'b1, d);
    pps_host_model_inst.select_mode();
    t = (xorshift() % 200) + 1;
    move(t, 32'h00000000, t);
    poll(`PPS_IDX_STAT, 32'h00000400, 32'h00000400);
    move(32'd50, 32'h00000040, t + 50);
    wr(`PPS_IDX_SWMAX, 32'd300);
    move(32'd1000, 32'h00000020, 32'd300);
    wr(`PPS_IDX_POSOPT, 32'h00000010);
    move(32'd20, 32'h00000000, 32'd20);
    rd(`PPS_IDX_CTRL, 32'h00000010, 32'h00000000, 1'b0, d);
    wr(`PPS_IDX_LOOPCFG, 32'h00000001);
    wr(`PPS_IDX_FEWIN, 32'd2);
    wr(`PPS_IDX_FETIME, 32'd1);
    posOffset <= 30;
    poll(`PPS_IDX_STAT, 32'h00002000, 32'h00002000);
    posOffset <= 0;
    wr(`PPS_IDX_TOLZONE, 32'd10);
    posLimitSw <= 1'b1;
    repeat (4 * TICKS) @(posedge ref_clk);
    posOffset <= 5;
    repeat (4 * TICKS) @(posedge ref_clk);
    check({31'h0, faultState}, 32'h00000000);
    posOffset <= 20;
    repeat (4 * TICKS) @(posedge ref_clk);
    check({31'h0, faultState}, 32'h00000001);
    poll(`PPS_IDX_STAT, 32'h00000008, 32'h00000008);
    posLimitSw <= 1'b0;
    posOffset <= 0;
    wr(`PPS_IDX_CTRL, 32'h00000080);
    poll(`PPS_IDX_STAT, 32'h00000008, 32'h00000000);
    negLimitSw <= 1'b1;
    repeat (4 * TICKS) @(posedge ref_clk);
    check({31'h0, faultState}, 32'h00000000);
    posOffset <= -20;
    repeat (4 * TICKS) @(posedge ref_clk);
    check({31'h0, faultState}, 32'h00000001);
    print_verdict();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
endmodule
